/* File: dv/lcdhi_host_model.sv */
`timescale 1ns/10ps
// host bus model: every pin the host drives changes just after a falling clock edge
module lcdhi_host_model (
    // clock
    input  wire logic       clk,
    // pins toward the device
    output logic            reset_pin_n,
    output logic            par_ser_sel,
    output logic            enable_scl,
    output logic            read_write,
    output logic            register_select_line,
    output logic [7:0]      data_bus_in,
    // device drive
    input  wire logic [7:0] data_bus_out,
    input  wire logic [7:0] data_bus_oe
);
    logic [7:0] drv_q;
    logic [7:0] hoe_q;

    // pins have pull-ups, so a line nobody drives reads high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            data_bus_in[i] = data_bus_oe[i] ? data_bus_out[i]
                           : (hoe_q[i] ? drv_q[i] : 1'h1);
        end
    end

    // idle: parallel, enable low, bus released
    initial begin
        reset_pin_n = 1'h1;
        par_ser_sel = 1'h1;
        enable_scl = 1'h0;
        read_write = 1'h0;
        register_select_line = 1'h0;
        drv_q = 8'h00;
        hoe_q = 8'h00;
    end

    // one enable cycle; 14 clocks keeps the cycle above 1 us
    task automatic par_acc(input logic rw, input logic rs,
                           input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        par_ser_sel = 1'h1;
        read_write = rw;
        register_select_line = rs;
        drv_q = d;
        hoe_q = rw ? 8'h00 : 8'hff;    // reads leave all lines free
        @(negedge clk);
        enable_scl = 1'h1;
        repeat (7) @(negedge clk);
        q = data_bus_in;
        enable_scl = 1'h0;
        repeat (2) @(negedge clk);
        hoe_q = 8'h00;
        repeat (3) @(negedge clk);
    endtask : par_acc

    // serial frame; clock idles low so the first bit is seen before a fall
    task automatic ser_acc(input logic rs, input logic rw, input int n,
                           input logic [15:0] bits, output logic [7:0] q);
        @(negedge clk);
        par_ser_sel = 1'h0;
        read_write = rw;
        register_select_line = rs;
        repeat (3) @(negedge clk);
        drv_q = 8'h00;
        hoe_q = rw ? 8'h80 : 8'hc0;           // chip select low
        repeat (5) @(negedge clk);
        q = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            drv_q[6] = bits[i];               // msb first
            repeat (5) @(negedge clk);
            q = {q[6:0], data_bus_in[6]};
            enable_scl = 1'h1;
            repeat (3) @(negedge clk);
            enable_scl = 1'h0;
        end
        repeat (3) @(negedge clk);
        hoe_q = 8'h00;
        repeat (8) @(negedge clk);
    endtask : ser_acc

    // reset pin pulse of n clocks
    task automatic pulse_rst(input int n);
        @(negedge clk);
        reset_pin_n = 1'h0;
        repeat (n) @(negedge clk);
        reset_pin_n = 1'h1;
        repeat (8) @(negedge clk);
    endtask : pulse_rst
endmodule : lcdhi_host_model

/* File: dv/tb_lcd_host_interface.sv */
`timescale 1ns/10ps
module tb_lcd_host_interface
    import lcdhi_pkg::*;
;
    localparam int RST_SIM = 20;
    logic        clk, resetn, reset_pin_n, par_ser_sel, enable_scl;
    logic        read_write, register_select_line, wr_valid, rd_done;
    logic        data_length_bit, display_blank, osc_tick, frame_start;
    logic [7:0]  data_bus_in, data_bus_out, data_bus_oe, rd_data, q;
    logic [4:0]  com_row, r;
    lcdhi_xfer_t wr_xfer, last_wr;
    lcdhi_stat_t status;
    int          n_errors, checks_done, cycles, n_wr, n_rd, n0, k, n_fs;

    lcdhi_host_port #(.RST_CYC(RST_SIM)) u_lcdhi_host_port (
        .clk(clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
        .par_ser_sel(par_ser_sel), .enable_scl(enable_scl),
        .read_write(read_write),
        .register_select_line(register_select_line),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .wr_valid(wr_valid), .wr_xfer(wr_xfer),
        .rd_done(rd_done), .status(status), .rd_data(rd_data),
        .data_length_bit(data_length_bit), .display_blank(display_blank),
        .osc_tick(osc_tick), .com_row(com_row), .frame_start(frame_start));

    lcdhi_host_model u_lcdhi_host_model (
        .clk(clk), .reset_pin_n(reset_pin_n), .par_ser_sel(par_ser_sel),
        .enable_scl(enable_scl), .read_write(read_write),
        .register_select_line(register_select_line),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe));

    initial clk = 1'h0;
    always #50 clk = ~clk;

    // collect delivered bytes and reads; cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (wr_valid === 1'h1) begin
            n_wr++;
            last_wr = wr_xfer;
        end
        if (rd_done === 1'h1) n_rd++;
        if (frame_start === 1'h1) n_fs++;
        if (cycles == 40000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [15:0] got,
                         input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // garbage on the low lines proves they are ignored in nibble mode
    task automatic put(input logic rs, input logic [7:0] d,
                       input logic nib);
        n0 = n_wr;
        if (nib) begin
            u_lcdhi_host_model.par_acc(1'h0, rs, {d[7:4], 4'h9}, q);
            check("nib_hold", n_wr - n0, 0);
            u_lcdhi_host_model.par_acc(1'h0, rs, {d[3:0], 4'h6}, q);
        end else begin
            u_lcdhi_host_model.par_acc(1'h0, rs, d, q);
        end
        check("wr_cnt", n_wr - n0, 1);
        check("wr_val", last_wr, {rs, d});
    endtask : put

    initial begin
        resetn = 1'h0;
        status = '{busy: 1'h1, addr: 7'h45};
        rd_data = 8'h96;
        repeat (16) @(negedge clk);
        resetn = 1'h1;
        repeat (4) @(negedge clk);
        check("dl_rst", data_length_bit, 1);
        check("blank", display_blank, 1);
        check("oe_idle", data_bus_oe, 0);
        u_lcdhi_host_model.par_acc(1'h1, 1'h0, 8'h00, q);
        check("stat8", q, 8'hc5);
        status = '{busy: 1'h0, addr: 7'h45};
        put(1'h0, 8'h20, 1'h0);
        check("dl4", data_length_bit, 0);
        put(1'h0, 8'h28, 1'h1);
        put(1'h1, 8'ha5, 1'h1);
        check("blank_off", display_blank, 0);
        // status after both nibbles; free low lines float high
        n0 = n_rd;
        u_lcdhi_host_model.par_acc(1'h1, 1'h0, 8'h00, q);
        check("stat_hi", q, 8'h4f);
        u_lcdhi_host_model.par_acc(1'h1, 1'h0, 8'h00, q);
        check("stat_lo", q, 8'h5f);
        check("rd_cnt", n_rd - n0, 1);
        // back to byte width by nibbles, then to nibbles by one byte
        put(1'h0, 8'h30, 1'h1);
        check("dl8", data_length_bit, 1);
        put(1'h0, 8'h20, 1'h0);
        check("dl4_again", data_length_bit, 0);
        // ten bits clocked: only the last eight survive
        n0 = n_wr;
        u_lcdhi_host_model.ser_acc(1'h1, 1'h0, 10, 16'h023c, q);
        check("ser_cnt", n_wr - n0, 1);
        check("ser_val", last_wr, 9'h13c);
        u_lcdhi_host_model.ser_acc(1'h0, 1'h0, 8, 16'h0030, q);
        check("ser_fset", last_wr, 9'h030);
        check("dl_ser", data_length_bit, 0);
        n0 = n_rd;
        u_lcdhi_host_model.ser_acc(1'h1, 1'h1, 8, 16'h0000, q);
        check("ser_rd", q, 8'h96);
        check("ser_rdn", n_rd - n0, 1);
        check("ser_oe", data_bus_oe, 0);
        // a short reset pulse is ignored, a full one reinitialises
        u_lcdhi_host_model.pulse_rst(5);
        check("rst_short", data_length_bit, 0);
        u_lcdhi_host_model.pulse_rst(RST_SIM + 5);
        check("rst_dl", data_length_bit, 1);
        check("rst_blank", display_blank, 1);
        // tick spacing, then ticks per common row
        for (int j = 0; j < 2; j++) begin
            k = 0;
            do begin
                @(posedge clk);
                #1 k++;
            end while (osc_tick !== 1'h1 && k < 300);
        end
        check("tick_gap", k, OSC_DIV);
        for (int j = 0; j < 2; j++) begin
            r = com_row;
            k = 0;
            n0 = 0;
            do begin
                @(posedge clk);
                #1 n0++;
                if (osc_tick === 1'h1) k++;
            end while (com_row === r && n0 < 9000);
        end
        check("row_ticks", k, ROW_TICKS);
        check("row_step", com_row, (r == 5'h11) ? 5'h00 : r + 5'h01);
        // a frame is 60 x 18 ticks, longer than this whole run
        check("no_frame", n_fs, 0);
        print_verdict();
    end
endmodule : tb_lcd_host_interface

/* File: hw/lcdhi_host_port.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - nibble mode uses upper four data lines
// - byte sent upper nibble then lower
// - status read returns as two nibbles
// - serial active when select low, cs low
// - serial bits move msb first
// - serial input sampled on clock rise
// - cs rise hands shifted byte over
// - extra bits: last eight kept
// - serial output shifts on clock fall
// - second command as nibbles, then nibble mode
// - display blank after init until data write
// - oscillator tick every 12.5 us
// - frame is 60 ticks times 18 rows
// - one eighteenth duty over 18 rows
// - byte mode selected after reset
// - busy set means next instruction waits
// - data-length bit picks width, parallel only
module lcdhi_host_port
    import lcdhi_pkg::*;
#(
    parameter int RST_CYC = RST_MIN_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // device pins, asynchronous to clk
    input  wire logic        reset_pin_n,
    input  wire logic        par_ser_sel,
    input  wire logic        enable_scl,
    input  wire logic        read_write,
    input  wire logic        register_select_line,
    input  wire logic [7:0]  data_bus_in,
    output logic      [7:0]  data_bus_out,
    output logic      [7:0]  data_bus_oe,
    // instruction side
    output logic             wr_valid,
    output lcdhi_xfer_t      wr_xfer,
    output logic             rd_done,
    input  wire lcdhi_stat_t status,
    input  wire logic [7:0]  rd_data,
    // state and display timing
    output logic             data_length_bit,
    output logic             display_blank,
    output logic             osc_tick,
    output logic [4:0]       com_row,
    output logic             frame_start
);
    localparam int NP = 13;
    logic init_n;
    default clocking chk_cb @(posedge clk); endclocking
    default disable iff (!init_n);

    if (RST_CYC < 1 || OSC_DIV < 2) begin : g_bad_timing
        $error("lcdhi: bad timing values");
    end

    // two-flop synchroniser on every pin; edges come from stage two only
    logic [NP-1:0] sy1_q, sy2_q, prv_q;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sy1_q <= PIN_IDLE;                           // idle: no false edge
            sy2_q <= PIN_IDLE;
            prv_q <= PIN_IDLE;
        end else begin
            sy1_q <= {reset_pin_n, par_ser_sel, enable_scl, read_write,
                      register_select_line, data_bus_in};
            sy2_q <= sy1_q;
            prv_q <= sy2_q;
        end
    end

    logic       rpin_n, ps, ep, rw, rs;
    logic [7:0] db;
    assign {rpin_n, ps, ep, rw, rs, db} = sy2_q;
    logic e_rise, e_fall, cs_n, cs_fall, cs_rise, ser_act;
    assign e_rise  = ep & ~prv_q[10];
    assign e_fall  = ~ep & prv_q[10];
    assign cs_n    = db[7];                              // chip select pin
    assign cs_fall = ~cs_n & prv_q[7];
    assign cs_rise = cs_n & ~prv_q[7];
    assign ser_act = ~ps & ~cs_n;

    // reset pin: must stay low RST_CYC cycles to count as a reset
    logic [$clog2(RST_CYC+1)-1:0] rlow_q;
    logic                         hw_rst;
    assign hw_rst = (rlow_q == ($bits(rlow_q))'(RST_CYC)) & rpin_n;
    always_ff @(posedge clk) begin
        if (!resetn || rpin_n)
            rlow_q <= '0;
        else if (rlow_q != ($bits(rlow_q))'(RST_CYC))
            rlow_q <= rlow_q + 1'b1;
    end
    assign init_n = resetn & ~hw_rst;

    // parallel: a write is taken on the enable fall
    logic       nib_lo_q;                                // lower nibble next
    logic [3:0] hi_nib_q;
    logic       par_wr, byte_done;
    logic [7:0] byte_now;
    assign par_wr    = ps & e_fall & ~rw;
    assign byte_now  = data_length_bit ? db : {hi_nib_q, db[7:4]};
    assign byte_done = par_wr & (data_length_bit | nib_lo_q);

    // interface width, nibble phase
    always_ff @(posedge clk) begin
        if (!init_n) begin
            data_length_bit <= DL_RESET;
            nib_lo_q        <= 1'b0;
            hi_nib_q        <= '0;
        end else if (byte_done && !rs &&
                     byte_now[7:FSET_POS] == FSET_CODE) begin
            data_length_bit <= byte_now[DL_POS];
            nib_lo_q        <= 1'b0;
        end else if (ps && e_fall && !data_length_bit) begin
            nib_lo_q <= ~nib_lo_q;                       // reads pair up too
            if (!rw && !nib_lo_q)
                hi_nib_q <= db[7:4];
        end
    end

    // serial shift register
    logic [7:0] sin_q, sout_q;
    logic       s_rs_q, s_rw_q, scl_rise, scl_fall;
    assign scl_rise = ser_act & e_rise;
    assign scl_fall = ser_act & e_fall;
    always_ff @(posedge clk) begin
        if (!init_n) begin
            sin_q  <= '0;
            sout_q <= '0;
            s_rs_q <= 1'b0;
            s_rw_q <= 1'b0;
        end else if (!ps && cs_fall) begin
            s_rs_q <= rs;
            s_rw_q <= rw;
            sout_q <= rs ? rd_data : status;
        end else if (scl_rise) begin
            sin_q <= {sin_q[6:0], db[6]};
        end else if (scl_fall) begin
            sout_q <= {sout_q[6:0], 1'b0};
        end
    end

    // byte hand-over to the instruction side, data from flops
    logic ser_wr;
    assign ser_wr = ~ps & cs_rise & ~s_rw_q;
    always_ff @(posedge clk) begin
        if (!init_n) begin
            wr_valid <= 1'b0;
            wr_xfer  <= '0;
        end else begin
            wr_valid <= byte_done | ser_wr;
            if (ser_wr)
                wr_xfer <= '{rs: s_rs_q, data: sin_q};
            else if (byte_done)
                wr_xfer <= '{rs: rs, data: byte_now};
        end
    end

    // read path: busy/address or data, halves in nibble mode
    logic [7:0] rd_byte, drv_q;
    logic       par_oe_q, rd_end;
    assign rd_byte = rs ? rd_data : status;
    assign rd_end  = (ps & e_fall & rw & (data_length_bit | nib_lo_q))
                   | (~ps & cs_rise & s_rw_q);
    always_ff @(posedge clk) begin
        if (!init_n) begin
            drv_q    <= '0;
            par_oe_q <= 1'b0;
            rd_done  <= 1'b0;
        end else begin
            rd_done <= rd_end;
            if (ps && e_rise && rw) begin
                par_oe_q <= 1'b1;
                if (data_length_bit)
                    drv_q <= rd_byte;
                else if (!nib_lo_q)
                    drv_q <= {rd_byte[7:4], 4'h0};
                else
                    drv_q <= {rd_byte[3:0], 4'h0};
            end else if (!ps || e_fall || !rw) begin
                par_oe_q <= 1'b0;
            end
        end
    end

    // pin drive: serial out on bit 6 only while selected
    logic s_oe;
    assign s_oe = ser_act & s_rw_q;
    always_comb begin
        data_bus_out = '0;
        data_bus_oe  = '0;
        if (ps && par_oe_q) begin
            data_bus_out = drv_q;
            data_bus_oe  = data_length_bit ? 8'hff : 8'hf0;
        end else if (s_oe) begin
            data_bus_out[6] = sout_q[7];
            data_bus_oe[6]  = 1'b1;
        end
    end

    // display stays blank from init until the first data write
    always_ff @(posedge clk) begin
        if (!init_n)
            display_blank <= 1'b1;
        else if (wr_valid && wr_xfer.rs)
            display_blank <= 1'b0;
    end

    // oscillator divider, row and frame counters
    logic [$clog2(OSC_DIV)-1:0]   div_q;
    logic [$clog2(ROW_TICKS)-1:0] tick_q;
    always_ff @(posedge clk) begin
        if (!init_n) begin
            div_q    <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= (div_q == ($bits(div_q))'(OSC_DIV - 1));
            if (div_q == ($bits(div_q))'(OSC_DIV - 1))
                div_q <= '0;
            else
                div_q <= div_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!init_n) begin
            tick_q      <= '0;
            com_row     <= '0;
            frame_start <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (osc_tick) begin
                if (tick_q == ($bits(tick_q))'(ROW_TICKS - 1)) begin
                    tick_q <= '0;
                    if (com_row == 5'(COM_ROWS - 1)) begin
                        com_row     <= '0;
                        frame_start <= 1'b1;
                    end else begin
                        com_row <= com_row + 1'b1;
                    end
                end else begin
                    tick_q <= tick_q + 1'b1;
                end
            end
        end
    end

    // checks
    osc_period_a: assert property (
        $rose(osc_tick) |=> !osc_tick [*8])
        else $error("oscillator tick repeated too soon");
    osc_spacing_a: assert property (
        osc_tick |-> ##125 osc_tick)
        else $error("oscillator tick spacing wrong");
    row_range_a: assert property (
        com_row < 5'(COM_ROWS))
        else $error("common row out of range");
    frame_wrap_a: assert property (
        frame_start |-> com_row == 5'h00 && $past(com_row) == 5'h11)
        else $error("frame start not at row wrap");
    cs_quiet_a: assert property (
        (!ps && cs_n) |-> !data_bus_oe[6])
        else $error("serial output driven with cs high");
    ser_shift_a: assert property (
        (scl_rise && !cs_fall) |=> sin_q[0] == $past(db[6]))
        else $error("serial bit not sampled on clock rise");
    ser_hand_a: assert property (
        ser_wr |=> wr_valid && wr_xfer.data == $past(sin_q))
        else $error("serial byte not handed over on cs rise");
    nib_order_a: assert property (
        (par_wr && !data_length_bit && !nib_lo_q && !hw_rst) |=> nib_lo_q)
        else $error("upper nibble not followed by lower");
    nib_pair_a: assert property (
        byte_done && !data_length_bit |=> wr_xfer.data[7:4] == $past(hi_nib_q))
        else $error("nibble byte misassembled");
    blank_hold_a: assert property (
        (display_blank && !(wr_valid && wr_xfer.rs)) |=> display_blank)
        else $error("display unblanked without data write");
    ser_out_a: assert property (
        (scl_fall && !cs_fall) |=> sout_q[7] == $past(sout_q[6]))
        else $error("serial output not shifted on fall");
endmodule : lcdhi_host_port

/* File: inc/lcdhi_pkg.sv */
package lcdhi_pkg;
    // clock and oscillator timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int OSC_HZ        = 80_000;
    localparam int OSC_DIV       = CLK_HZ / OSC_HZ;        // 12.5 us per tick
    localparam int ROW_TICKS     = 60;
    localparam int COM_ROWS      = 18;
    // hardware reset pin least low width
    localparam int RST_MIN_US10  = 12;                     // 1.2 ms in 0.1 ms
    localparam int RST_MIN_CYC   = (CLK_HZ / 10_000) * RST_MIN_US10;
    // function set decode
    localparam logic [2:0] FSET_CODE = 3'h1;               // top bits 001
    localparam int         FSET_POS  = 5;
    localparam int         DL_POS    = 4;
    localparam logic       DL_RESET  = 1'h1;               // 8-bit after reset
    localparam logic [7:0] SPACE_CHR = 8'h20;
    // pin idle levels {reset, p/s, enable, r/w, select, bus pulled high}
    localparam logic [12:0] PIN_IDLE = 13'h18ff;

    // one received byte with its register select
    typedef struct packed {
        logic       rs;
        logic [7:0] data;
    } lcdhi_xfer_t;

    // one read answer: status byte is busy and address counter
    typedef struct packed {
        logic       busy;
        logic [6:0] addr;
    } lcdhi_stat_t;
endpackage : lcdhi_pkg
